// ==== rtl/bcl_top.sv ====
`timescale 1ns/1ps
// How it works
// - Trip reference is (code+1) steps of 6.25 percent; code in bits 9:6.
// - PWM high, or start-up, keeps drive on until current trips.
// - On trip, high sides off, complementary low sides on: slow decay.
// - Off-time is 10 us plus code times 1.6 us, code in bits 4:0.
// - Comparator ignored for blank time whenever drive configuration starts.
// - Blank time is code times 400 ns, code in bits 9:6.
// - Drain-source short monitors use the same blank interval.
// - Diagnostic pin shows one of four sources picked by run bits 5:4.
// - Power-on reset selects the general fault flag on the pin.
// - Fault flag low while unlatched fault present or latched disable holds.
// - Sensorless indicator follows state, held while stopped or braking.
// - Clock source gives a divided square wave on the pin.
// - Bit 15 is set if any fault bit set; first serial bit.
// - Diagnostic fault bits stay latched until a diagnostic register read, sleep clear, or reset.
// - Stop-on-fault with short or overtemperature forces all gates off.
// - Short-fault disable holds until sleep clear, diagnostic register read, or reset.
// - Logic or regulator undervoltage always disables the outputs; bootstrap undervoltage only when unmasked.
// - Stop-on-fault clear: flag goes low but drive keeps running.
// - Masked diagnostic produces no fault state, flag, or register bit.
// - Logic and regulator undervoltage can never be masked.
// - PWM ignored in start-up except held low to request braking.
module bcl_top #(
  parameter logic [bcl_pkg::CNT_W-1:0] OFF_BASE_CYC = bcl_pkg::OFF_BASE_CYC
) (
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        pwm_in,
  input  wire logic        cur_comp_in,
  input  wire logic [5:0]  ds_short_in,
  input  wire logic        vdd_uv_in,
  input  wire logic        vreg_uv_in,
  input  wire logic        temp_warn_in,
  input  wire logic        over_temp_in,
  input  wire logic [2:0]  boot_uv_in,
  input  wire logic        vds_thresh_in,
  input  wire logic        sleep_clear_n_in,
  input  wire logic        serial_strobe_n_in,
  input  wire logic        startup_in,
  input  wire logic        sensorless_ok_in,
  input  wire logic [2:0]  comm_high_in,
  input  wire logic [2:0]  comm_low_in,
  output logic      [2:0]  gate_high_out,
  output logic      [2:0]  gate_low_out,
  output logic             out_pin_a_out,
  output logic      [4:0]  trip_ref_step_out,
  output logic             serial_first_bit_out
);
  import bcl_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 18;
  // Active-low strobe and sleep clear reset to their idle high level
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 18'h30000;
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              pwm_s;
  logic              comp_s;
  logic [5:0]        short_s;
  logic              vdd_s;
  logic              vreg_s;
  logic              tw_s;
  logic              ts_s;
  logic [2:0]        boot_s;
  logic              vds_s;
  logic              sleep_n_s;
  logic              strobe_n_s;

  assign raw_in = {serial_strobe_n_in, sleep_clear_n_in, vds_thresh_in, boot_uv_in,
                   over_temp_in, temp_warn_in, vreg_uv_in, vdd_uv_in, ds_short_in,
                   cur_comp_in, pwm_in};

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  assign {strobe_n_s, sleep_n_s, vds_s, boot_s, ts_s, tw_s, vreg_s, vdd_s, short_s,
          comp_s, pwm_s} = sync2_q;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [31:0]        cfg0_q;
  logic [31:0]        cfg1_q;
  logic [31:0]        cfg2_q;
  logic [31:0]        run_q;
  logic [FAULT_W-1:0] mask_q;
  logic [OUT_PIN_A_POR:0]  out_pin_a_q;
  logic               por_q;
  logic [31:0]        rdata_d;
  logic               hit_d;
  logic               xfer_done;
  logic               wr_en;
  logic               out_pin_a_read;
  logic               ff_bit;

  assign xfer_done = psel_in & penable_in & pready_out;
  assign wr_en     = xfer_done & pwrite_in & ~pslverr_out;
  assign out_pin_a_read = xfer_done & ~pwrite_in & (paddr_in == ADDR_OUT_PIN_A);
  assign ff_bit    = |out_pin_a_q;

  always_comb begin
    rdata_d = RESET_ZERO;
    hit_d   = 1'b1;
    unique case (paddr_in)
      ADDR_CFG0: rdata_d = cfg0_q;
      ADDR_CFG1: rdata_d = cfg1_q;
      ADDR_CFG2: rdata_d = cfg2_q;
      ADDR_RUN:  rdata_d = run_q;
      ADDR_MASK: rdata_d[FAULT_W-1:0] = mask_q;
      ADDR_OUT_PIN_A: begin
        rdata_d[OUT_PIN_A_POR:0] = out_pin_a_q;
        rdata_d[OUT_PIN_A_FF]    = ff_bit;
      end
      default:   hit_d = 1'b0;
    endcase
  end

  // Single wait-free access phase: answer loaded in the setup cycle
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= RESET_ZERO;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~hit_d;
      if (psel_in & ~penable_in & ~pwrite_in) begin
        prdata_out <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cfg0_q <= RESET_ZERO;
      cfg1_q <= RESET_ZERO;
      cfg2_q <= RESET_ZERO;
      run_q  <= RESET_ZERO;
      mask_q <= '0;
    end else if (wr_en) begin
      unique case (paddr_in)
        ADDR_CFG0: cfg0_q <= pwdata_in;
        ADDR_CFG1: cfg1_q <= pwdata_in;
        ADDR_CFG2: cfg2_q <= pwdata_in;
        ADDR_RUN:  run_q  <= pwdata_in;
        ADDR_MASK: mask_q <= pwdata_in[FAULT_W-1:0] & MASK_WRITABLE;
        default:   mask_q <= mask_q;
      endcase
    end
  end

  logic [3:0]   blank_time_code;
  logic [3:0]   trip_ref_code;
  logic [4:0]   off_time_code;
  logic         run_bit;
  logic         brake_request;
  logic         stop_on_fault;
  bcl_dsel_type out_pin_a_pin_select;

  assign blank_time_code = cfg0_q[BLANK_MSB:BLANK_LSB];
  assign trip_ref_code   = cfg1_q[TRIP_MSB:TRIP_LSB];
  assign off_time_code   = cfg2_q[OFF_MSB:OFF_LSB];
  assign run_bit         = run_q[RUN_BIT];
  assign brake_request   = run_q[BRAKE_BIT];
  assign stop_on_fault   = run_q[STOP_BIT];
  assign out_pin_a_pin_select = bcl_dsel_type'(run_q[DSEL_MSB:DSEL_LSB]);

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      trip_ref_step_out <= 5'h01;
    end else begin
      trip_ref_step_out <= {1'b0, trip_ref_code} + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Fault detection and response
  // ----------------------------------------------------------------
  bcl_state_type      state_q;
  logic               blank_active;
  logic [5:0]         short_m;
  logic [2:0]         boot_m;
  logic               tw_m;
  logic               ts_m;
  logic [FAULT_W-1:0] fault_set;
  logic               fault_clr;
  logic               disable_latch_q;
  logic               outputs_off;
  logic               unlatched_present;

  assign blank_active = (state_q == ST_BLANK);
  assign short_m = short_s & ~mask_q[OUT_PIN_A_SHORT +: 6] & {6{~blank_active}};
  assign boot_m  = boot_s & ~mask_q[OUT_PIN_A_BOOT +: 3];
  assign tw_m    = tw_s & ~mask_q[OUT_PIN_A_TW];
  assign ts_m    = ts_s & ~mask_q[OUT_PIN_A_TS];
  assign fault_set = {vreg_s, vdd_s, tw_m, ts_m, boot_m, 1'b0, short_m};
  assign fault_clr = ~sleep_n_s | out_pin_a_read;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      disable_latch_q <= 1'b0;
    end else if ((|boot_m) | (stop_on_fault & (|short_m))) begin
      disable_latch_q <= 1'b1;
    end else if (fault_clr) begin
      disable_latch_q <= 1'b0;
    end
  end

  assign outputs_off = vdd_s | vreg_s | disable_latch_q | (stop_on_fault & ts_m);
  assign unlatched_present = vdd_s | vreg_s | tw_m | ts_m | (|short_m);

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      out_pin_a_q <= '0;
      por_q  <= 1'b1;
    end else begin
      por_q <= por_q & ~fault_clr;
      out_pin_a_q[FAULT_W-1:0] <= (fault_clr ? '0 : out_pin_a_q[FAULT_W-1:0]) | fault_set;
      out_pin_a_q[OUT_PIN_A_POR]    <= por_q & ~fault_clr;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      serial_first_bit_out <= 1'b0;
    end else begin
      serial_first_bit_out <= ~strobe_n_s & ff_bit;
    end
  end

  // ----------------------------------------------------------------
  // Chopping state machine
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] blank_load;
  logic [CNT_W-1:0] off_load;
  logic [2:0]       comm_prev_q;
  logic             comm_change;
  logic             braking;
  logic             drive_on;
  logic             cur_trip;

  assign blank_load  = CNT_W'(blank_time_code) * BLANK_UNIT_CYC;
  assign off_load    = OFF_BASE_CYC + CNT_W'(off_time_code) * OFF_STEP_CYC;
  assign comm_change = (comm_high_in != comm_prev_q);
  assign braking  = brake_request & (~startup_in | ~pwm_s);
  assign drive_on = run_bit & ~braking & ~outputs_off & (startup_in | pwm_s);
  assign cur_trip = comp_s & (state_q == ST_DRIVE);

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      comm_prev_q <= '0;
    end else begin
      comm_prev_q <= comm_high_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end else if (!drive_on) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          state_q <= (blank_load == '0) ? ST_DRIVE : ST_BLANK;
          cnt_q   <= blank_load;
        end
        ST_BLANK: begin
          cnt_q <= cnt_q - CNT_ONE;
          if (cnt_q <= CNT_ONE) begin
            state_q <= ST_DRIVE;
          end
        end
        ST_DRIVE: begin
          if (cur_trip) begin
            state_q <= ST_OFF;
            cnt_q   <= off_load;
          end else if (comm_change && blank_load != '0) begin
            state_q <= ST_BLANK;
            cnt_q   <= blank_load;
          end
        end
        ST_OFF: begin
          cnt_q <= cnt_q - CNT_ONE;
          if (cnt_q <= CNT_ONE) begin
            state_q <= (blank_load == '0) ? ST_DRIVE : ST_BLANK;
            cnt_q   <= blank_load;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Gate outputs
  // ----------------------------------------------------------------
  logic [2:0] high_d;
  logic [2:0] low_d;

  always_comb begin
    high_d = '0;
    low_d  = '0;
    if (outputs_off || !run_bit) begin
      high_d = '0;
      low_d  = '0;
    end else if (braking) begin
      low_d = GATE_ALL;
    end else if (state_q == ST_BLANK || state_q == ST_DRIVE) begin
      high_d = comm_high_in;
      low_d  = comm_low_in;
    end else begin
      low_d = comm_low_in | comm_high_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      gate_high_out <= '0;
      gate_low_out  <= '0;
    end else begin
      gate_high_out <= high_d;
      gate_low_out  <= low_d;
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic pin
  // ----------------------------------------------------------------
  logic [6:0] div_cnt_q;
  logic       div_clk_q;
  logic       sensorless_q;
  logic       fault_flag_n;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      div_cnt_q <= '0;
      div_clk_q <= 1'b0;
    end else if (div_cnt_q == 7'(OUT_PIN_A_CLK_HALF_CYC - 1)) begin
      div_cnt_q <= '0;
      div_clk_q <= ~div_clk_q;
    end else begin
      div_cnt_q <= div_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sensorless_q <= 1'b0;
    end else if (run_bit && !brake_request) begin
      sensorless_q <= sensorless_ok_in;
    end
  end

  assign fault_flag_n = ~(unlatched_present | disable_latch_q);

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      out_pin_a_out <= 1'b1;
    end else begin
      unique case (out_pin_a_pin_select)
        DSEL_FAULT:      out_pin_a_out <= fault_flag_n;
        DSEL_SENSORLESS: out_pin_a_out <= sensorless_q;
        DSEL_VDS:        out_pin_a_out <= vds_s;
        DSEL_CLOCK:      out_pin_a_out <= div_clk_q;
      endcase
    end
  end

endmodule : bcl_top

// ==== rtl/bcl_pkg.sv ====
package bcl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int BLANK_UNIT_NS  = 400;
  localparam int OFF_BASE_NS    = 10000;
  localparam int OFF_STEP_NS    = 1600;
  localparam int CNT_W          = 13;
  localparam logic [CNT_W-1:0] BLANK_UNIT_CYC = CNT_W'(BLANK_UNIT_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OFF_BASE_CYC   = CNT_W'(OFF_BASE_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OFF_STEP_CYC   = CNT_W'(OFF_STEP_NS / CLK_PERIOD_NS);
  localparam int OUT_PIN_A_CLK_HALF_CYC = 50;
  localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG0 = 8'h00;
  localparam logic [7:0] ADDR_CFG1 = 8'h04;
  localparam logic [7:0] ADDR_CFG2 = 8'h08;
  localparam logic [7:0] ADDR_RUN  = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_OUT_PIN_A = 8'h14;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int BLANK_LSB  = 6;
  localparam int BLANK_MSB  = 9;
  localparam int TRIP_LSB   = 6;
  localparam int TRIP_MSB   = 9;
  localparam int OFF_LSB    = 0;
  localparam int OFF_MSB    = 4;
  localparam int RUN_BIT    = 0;
  localparam int BRAKE_BIT  = 2;
  localparam int DSEL_LSB   = 4;
  localparam int DSEL_MSB   = 5;
  localparam int STOP_BIT   = 6;
  localparam int OUT_PIN_A_FF    = 15;
  localparam int OUT_PIN_A_POR   = 14;
  localparam int OUT_PIN_A_VREG  = 13;
  localparam int OUT_PIN_A_VDD   = 12;
  localparam int OUT_PIN_A_TW    = 11;
  localparam int OUT_PIN_A_TS    = 10;
  localparam int OUT_PIN_A_BOOT  = 7;
  localparam int OUT_PIN_A_SHORT = 0;
  localparam int FAULT_W    = 14;

  // Logic and regulator undervoltage mask bits are not implemented and read zero
  localparam logic [FAULT_W-1:0] MASK_WRITABLE = 14'h0FFF;
  localparam logic [31:0]        RESET_ZERO    = 32'h0000_0000;
  localparam logic [2:0]         GATE_ALL      = 3'h7;

  typedef enum logic [1:0] {
    DSEL_FAULT     = 2'b00,
    DSEL_SENSORLESS = 2'b01,
    DSEL_VDS       = 2'b10,
    DSEL_CLOCK     = 2'b11
  } bcl_dsel_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BLANK = 2'b01,
    ST_DRIVE = 2'b10,
    ST_OFF   = 2'b11
  } bcl_state_type;

endpackage : bcl_pkg

// ==== bench/bcl_asserts.sv ====
`timescale 1ns/1ps
// ----------------
// Checker
// ----------------
module bcl_asserts #(
  parameter logic [bcl_pkg::CNT_W-1:0] OFF_BASE_CYC = 13'h03E8
) (
  input wire logic        ref_clk_in,
  input wire logic        srst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic        vdd_uv_in,
  input wire logic        vreg_uv_in,
  input wire logic        over_temp_in,
  input wire logic        vds_thresh_in,
  input wire logic        serial_strobe_n_in,
  input wire logic        sensorless_ok_in,
  input wire logic [2:0]  gate_high_out,
  input wire logic [2:0]  gate_low_out,
  input wire logic        out_pin_a_out,
  input wire logic        serial_first_bit_out
);
  import bcl_pkg::*;
  logic [1:0] sel_q;
  logic [3:0] csel_q;
  logic       run_q, brk_q, stop_q, wr_run;
  assign wr_run = psel_in && penable_in && pready_out && pwrite_in && paddr_in == ADDR_RUN;
  // Shadow of run-control fields seen on the bus
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      {stop_q, sel_q, brk_q, run_q} <= 5'h00;
    end else if (wr_run) begin
      {stop_q, sel_q, brk_q, run_q} <= {pwdata_in[STOP_BIT], pwdata_in[DSEL_MSB:DSEL_LSB],
                                         pwdata_in[BRAKE_BIT], pwdata_in[RUN_BIT]};
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      csel_q <= 4'h0;
    end else begin
      csel_q <= {csel_q[2:0], sel_q == 2'h3};
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  sequence s_clk_rise;
    csel_q == 4'hF && $rose(out_pin_a_out);
  endsequence
  sequence s_clk_high;
    $stable(out_pin_a_out)[*8] ##42 $fell(out_pin_a_out);
  endsequence
  setup_ready_a: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
    else $error("ready not one cycle after setup");
  uv_off_a: assert property ((vdd_uv_in || vreg_uv_in)[*4] |->
    gate_high_out == 3'h0 && gate_low_out == 3'h0) else $error("gates on in undervoltage");
  otemp_off_a: assert property ((stop_q && over_temp_in)[*4] |->
    gate_high_out == 3'h0 && gate_low_out == 3'h0) else $error("gates on in overtemp");
  flag_low_a: assert property ((sel_q == 2'h0 && vreg_uv_in)[*5] |-> !out_pin_a_out)
    else $error("fault flag not low");
  pin_vds_a: assert property ((sel_q == 2'h2 && $stable(vds_thresh_in))[*5] |->
    out_pin_a_out == vds_thresh_in) else $error("pin not showing threshold");
  pin_sensorless_a: assert property ((sel_q == 2'h1 && run_q && !brk_q
    && $stable(sensorless_ok_in))[*4] |-> out_pin_a_out == sensorless_ok_in)
    else $error("pin not showing sensorless state");
  pin_clock_a: assert property (s_clk_rise |=> s_clk_high)
    else $error("pin clock half period wrong");
  serial_idle_a: assert property (serial_strobe_n_in[*4] |-> !serial_first_bit_out)
    else $error("serial bit high without strobe");
  serial_ff_a: assert property ((!serial_strobe_n_in && vreg_uv_in)[*5] |->
    serial_first_bit_out) else $error("serial bit low with fault");
endmodule : bcl_asserts

bind bcl_top bcl_asserts #(.OFF_BASE_CYC(OFF_BASE_CYC)) u_bcl_asserts (.ref_clk_in, .srst_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .vdd_uv_in,
  .vreg_uv_in, .over_temp_in, .vds_thresh_in, .serial_strobe_n_in, .sensorless_ok_in,
  .gate_high_out, .gate_low_out, .out_pin_a_out, .serial_first_bit_out);

// ==== bench/bcl_bridge_model.sv ====
`timescale 1ns/1ps
// ----------------
// Bridge and motor
// ----------------
module bcl_bridge_model (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic [2:0] gate_high_in,
  input  wire logic       short_in,
  input  wire logic       spike_in,
  output logic            cur_comp_out,
  output logic [5:0]      ds_short_out
);
  logic [3:0] cur_q;
  logic [3:0] on_q;
  // Winding current rises while driven, decays while recirculating
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cur_q <= 4'h0;
    end else if (gate_high_in != 3'h0 && cur_q != 4'hF) begin
      cur_q <= cur_q + 4'h1;
    end else if (gate_high_in == 3'h0 && cur_q != 4'h0) begin
      cur_q <= cur_q - 4'h1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in || gate_high_in == 3'h0) begin
      on_q <= 4'h0;
    end else if (on_q != 4'hF) begin
      on_q <= on_q + 4'h1;
    end
  end
  assign cur_comp_out = cur_q >= 4'h8;
  // Switching transient lasts ten cycles after turn-on
  assign ds_short_out = (short_in || (spike_in && gate_high_in != 3'h0 && on_q < 4'hA))
                        ? 6'h3F : 6'h00;
endmodule : bcl_bridge_model

// ==== bench/test_bcl_top.sv ====
`timescale 1ns/1ps
`define PE @(posedge ref_clk_in)
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: got %0h want %0h", $time, (a), (b)); end end
module test_bcl_top;
  import bcl_pkg::*;
  localparam logic [CNT_W-1:0] OFF_B = 13'h0014;
  logic ref_clk_in = 1'b0, srst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0, pwm_in = 1'b1, vdd_uv_in = 1'b0, vreg_uv_in = 1'b0;
  logic temp_warn_in = 1'b0, over_temp_in = 1'b0, vds_thresh_in = 1'b0;
  logic sleep_clear_n_in = 1'b1, serial_strobe_n_in = 1'b1, startup_in = 1'b0;
  logic sensorless_ok_in = 1'b0, short_cmd = 1'b0, spike_cmd = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rdat;
  logic [2:0]  boot_uv_in = 3'h0, comm_high_in = 3'h1, comm_low_in = 3'h2;
  logic [2:0]  gate_high_out, gate_low_out;
  logic [5:0]  ds_short_in;
  logic [4:0]  trip_ref_step_out;
  logic pready_out, pslverr_out, cur_comp_in, out_pin_a_out, serial_first_bit_out;
  logic rerr, hi_seen, lo_seen;
  int   num_errors = 0, n_compared = 0, cnt;
  int   cnt_tab[3] = '{0, 12, 15};
  bcl_top #(.OFF_BASE_CYC(OFF_B)) u_bcl_top (.ref_clk_in, .srst_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .pwm_in,
    .cur_comp_in, .ds_short_in, .vdd_uv_in, .vreg_uv_in, .temp_warn_in, .over_temp_in,
    .boot_uv_in, .vds_thresh_in, .sleep_clear_n_in, .serial_strobe_n_in, .startup_in,
    .sensorless_ok_in, .comm_high_in, .comm_low_in, .gate_high_out, .gate_low_out,
    .out_pin_a_out, .trip_ref_step_out, .serial_first_bit_out);
  bcl_bridge_model u_bcl_bridge_model (.clk_in(ref_clk_in), .srst_in, .short_in(short_cmd),
    .gate_high_in(gate_high_out), .spike_in(spike_cmd), .cur_comp_out(cur_comp_in),
    .ds_short_out(ds_short_in));
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic test_done;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : idle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    `PE {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, d};
    `PE penable_in <= 1'b1;
    do `PE; while (pready_out !== 1'b1);
    rdat = prdata_out;
    rerr = pslverr_out;
    {psel_in, penable_in} <= 2'b00;
  endtask : bus
  task automatic watch(input int n);
    hi_seen = 1'b0;
    lo_seen = 1'b0;
    repeat (n) begin
      idle(1);
      if (gate_high_out !== 3'h0) hi_seen = 1'b1;
      if (out_pin_a_out !== 1'b1) lo_seen = 1'b1;
    end
  endtask : watch
  task automatic chop(input int bc, input int oc);
    int on_n, off_n;
    bus(1'b1, ADDR_CFG0, 32'(bc) << BLANK_LSB);
    bus(1'b1, ADDR_CFG2, 32'(oc));
    on_n = 0;
    off_n = 0;
    while (gate_high_out !== 3'h0) idle(1);
    while (gate_high_out === 3'h0) idle(1);
    while (gate_high_out !== 3'h0) begin on_n++; idle(1); end
    `CHK(gate_low_out[0], 1'b1)
    while (gate_high_out === 3'h0) begin off_n++; idle(1); end
    `CHK(off_n, int'(OFF_B) + oc * int'(OFF_STEP_CYC))
    `CHK(on_n >= bc * 40 && on_n <= bc * 40 + 16, 1'b1)
  endtask : chop
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    num_errors++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    idle(1);
    `CHK({out_pin_a_out, trip_ref_step_out}, 6'h21)
    bus(1'b0, ADDR_OUT_PIN_A, 32'h0);
    `CHK(rdat[15:14], 2'b11)
    bus(1'b0, ADDR_OUT_PIN_A, 32'h0);
    `CHK(rdat, RESET_ZERO)
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 32'h0);
    `CHK({rerr, rdat}, {1'b1, RESET_ZERO})
    bus(1'b1, ADDR_MASK, 32'hFFFF_FFFF);
    bus(1'b0, ADDR_MASK, 32'h0);
    `CHK(rdat, 32'(MASK_WRITABLE))
    bus(1'b1, ADDR_MASK, 32'h0);
    foreach (cnt_tab[i]) begin
      bus(1'b1, ADDR_CFG1, 32'(cnt_tab[i]) << TRIP_LSB);
      idle(2);
      `CHK(trip_ref_step_out, 5'(cnt_tab[i] + 1))
    end
    bus(1'b1, ADDR_RUN, 32'h01);
    chop(15, 31);
    chop(0, 0);
    chop(2, 1);
    `PE pwm_in <= 1'b0;
    idle(6);
    `CHK(gate_high_out, 3'h0)
    `PE startup_in <= 1'b1;
    idle(6);
    `CHK(gate_high_out, 3'h1)
    bus(1'b1, ADDR_RUN, 32'h05);
    idle(6);
    `CHK({gate_high_out, gate_low_out}, 6'h07)
    `PE pwm_in <= 1'b1;
    idle(6);
    `CHK(gate_high_out, 3'h1)
    `PE startup_in <= 1'b0;
    bus(1'b1, ADDR_RUN, 32'h11);
    idle(2);
    `CHK(out_pin_a_out, 1'b0)
    `PE sensorless_ok_in <= 1'b1;
    idle(4);
    `CHK(out_pin_a_out, 1'b1)
    bus(1'b1, ADDR_RUN, 32'h10);
    `PE sensorless_ok_in <= 1'b0;
    idle(4);
    `CHK(out_pin_a_out, 1'b1)
    bus(1'b1, ADDR_RUN, 32'h21);
    idle(2);
    `CHK(out_pin_a_out, 1'b0)
    `PE vds_thresh_in <= 1'b1;
    idle(5);
    `CHK(out_pin_a_out, 1'b1)
    bus(1'b1, ADDR_RUN, 32'h31);
    while (out_pin_a_out !== 1'b1) idle(1);
    while (out_pin_a_out === 1'b1) idle(1);
    cnt = 0;
    while (out_pin_a_out === 1'b0) begin cnt++; idle(1); end
    `CHK(cnt, OUT_PIN_A_CLK_HALF_CYC)
    while (out_pin_a_out === 1'b1) idle(1);
    bus(1'b1, ADDR_RUN, 32'h41);
    `PE spike_cmd <= 1'b1;
    watch(600);
    `CHK({hi_seen, lo_seen}, 2'b10)
    `PE {spike_cmd, short_cmd} <= 2'b01;
    idle(300);
    `CHK({gate_high_out, gate_low_out}, 6'h00)
    `PE {short_cmd, serial_strobe_n_in} <= 2'b00;
    watch(100);
    `CHK({hi_seen, lo_seen, serial_first_bit_out}, 3'b011)
    `PE serial_strobe_n_in <= 1'b1;
    bus(1'b0, ADDR_OUT_PIN_A, 32'h0);
    `CHK({rdat[OUT_PIN_A_FF], rdat[OUT_PIN_A_SHORT]}, 2'b11)
    idle(20);
    `CHK(gate_high_out, 3'h1)
    `PE short_cmd <= 1'b1;
    idle(300);
    `PE {short_cmd, sleep_clear_n_in} <= 2'b00;
    idle(4);
    `PE sleep_clear_n_in <= 1'b1;
    idle(20);
    `CHK(gate_high_out, 3'h1)
    bus(1'b1, ADDR_RUN, 32'h01);
    `PE short_cmd <= 1'b1;
    watch(400);
    `CHK({hi_seen, lo_seen}, 2'b11)
    bus(1'b1, ADDR_MASK, 32'h3F);
    bus(1'b0, ADDR_OUT_PIN_A, 32'h0);
    `CHK(rdat[OUT_PIN_A_SHORT], 1'b1)
    watch(300);
    `CHK({hi_seen, lo_seen}, 2'b10)
    `PE short_cmd <= 1'b0;
    bus(1'b0, ADDR_OUT_PIN_A, 32'h0);
    `CHK(rdat[5:0], 6'h00)
    bus(1'b1, ADDR_RUN, 32'h41);
    `PE over_temp_in <= 1'b1;
    idle(6);
    `CHK({gate_high_out, gate_low_out}, 6'h00)
    `PE over_temp_in <= 1'b0;
    bus(1'b1, ADDR_MASK, 32'h0FFF);
    `PE {vdd_uv_in, serial_strobe_n_in} <= 2'b10;
    idle(6);
    `CHK({gate_high_out, gate_low_out, out_pin_a_out}, 7'h00)
    `PE {vdd_uv_in, vreg_uv_in} <= 2'b01;
    idle(6);
    `CHK({gate_high_out, serial_first_bit_out}, 4'h1)
    `PE {vreg_uv_in, serial_strobe_n_in} <= 2'b01;
    idle(6);
    test_done();
  end
endmodule : test_bcl_top
